// file: hdl/eima_top.sv
// event flag latch, mask registers and interrupt line driver
`timescale 1ns/100ps
module eima_top
    import eima_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [4:0]  system_evt,
    input  wire logic [7:0]  supply_evt,
    input  wire logic        charger_wake_input,
    input  wire logic        temp_high_evt,
    input  wire logic [15:0] general_input_evt,
    input  wire logic [2:0]  analog_threshold_evt,
    input  wire logic        fast_two_wire_port_hit,
    input  wire logic        power_up_active,
    output logic             interrupt_request_line_n,
    output logic             irq_q
);
    logic [7:0]  evt_q [4];
    logic [7:0]  mask_q [4];
    logic [7:0]  hold_q [4];
    logic        wake_dly_q;
    logic        pu_block_q;
    logic        ready_q;
    logic [7:0]  raw [4];
    logic [7:0]  clr [4];
    logic        wr_acc;
    logic        rd_acc;
    logic [7:0]  idx;
    logic        mapped;
    logic [31:0] rdata_d;
    logic        pend;
    logic        any_evt;

    assign idx    = paddr[9:2];
    // writes land on the edge where pready is seen high, never on unmapped words
    assign wr_acc = psel & penable & pwrite & ready_q & mapped;
    assign rd_acc = psel & penable & ~pwrite & ~ready_q;
    assign mapped = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0)
                    && (idx >= EIMA_IDX_EVT_A) && (idx <= EIMA_IDX_CTRL);

    // gather raw sources into register positions
    always_comb begin
        raw[0] = {3'h0, system_evt};
        raw[1] = supply_evt;
        raw[1][EIMA_BIT_WAKE] = supply_evt[EIMA_BIT_WAKE]
                                | (charger_wake_input & ~wake_dly_q);
        raw[1][EIMA_BIT_TEMP] = supply_evt[EIMA_BIT_TEMP] | temp_high_evt;
        raw[2] = general_input_evt[7:0];
        raw[2][2:0] = general_input_evt[2:0] | analog_threshold_evt;
        raw[3] = general_input_evt[15:8];
        raw[3][EIMA_BIT_FAST] = general_input_evt[14] | fast_two_wire_port_hit;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wake_dly_q <= 1'b0;
        end else begin
            wake_dly_q <= charger_wake_input;
        end
    end

    // write-back-to-clear, sticky flags, set never lost
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_evt
            assign clr[g] = (wr_acc && idx == EIMA_IDX_EVT_A + 8'(g) && pstrb[0])
                            ? pwdata[7:0] : 8'h00;
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    evt_q[g]  <= EIMA_EVT_RESET;
                    hold_q[g] <= EIMA_EVT_RESET;
                end else if (clr[g] != 8'h00) begin
                    // arrivals during the clear cycle go to hold, not lost
                    evt_q[g]  <= evt_q[g] & ~clr[g];
                    hold_q[g] <= hold_q[g] | raw[g];
                end else begin
                    evt_q[g]  <= evt_q[g] | raw[g] | hold_q[g];
                    hold_q[g] <= EIMA_EVT_RESET;
                end
            end
        end
    endgenerate

    // mask registers; first one has reserved top bits
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) mask_q[i] <= EIMA_MASK_RESET;
        end else if (wr_acc && pstrb[0]) begin
            if (idx == EIMA_IDX_MASK_A) mask_q[0] <= pwdata[7:0] & EIMA_MASK_A_IMPL;
            if (idx == EIMA_IDX_MASK_B) mask_q[1] <= pwdata[7:0];
            if (idx == EIMA_IDX_MASK_C) mask_q[2] <= pwdata[7:0];
            if (idx == EIMA_IDX_MASK_D) mask_q[3] <= pwdata[7:0];
        end
    end

    assign any_evt = (evt_q[0] | evt_q[1] | evt_q[2] | evt_q[3]
                      | hold_q[0] | hold_q[1] | hold_q[2] | hold_q[3]) != 8'h00;

    // power-up blocking releases only once everything is clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pu_block_q <= 1'b1;
        end else if (power_up_active) begin
            pu_block_q <= 1'b1;
        end else if (!any_evt) begin
            pu_block_q <= 1'b0;
        end
    end

    always_comb begin
        pend = 1'b0;
        for (int i = 0; i < 4; i++) pend = pend | ((evt_q[i] & ~mask_q[i]) != 8'h00);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_q                    <= 1'b0;
            interrupt_request_line_n <= 1'b1;
        end else begin
            irq_q                    <= pend & ~pu_block_q & ~power_up_active;
            interrupt_request_line_n <= ~(pend & ~pu_block_q & ~power_up_active);
        end
    end

    // read mux with summary bits
    always_comb begin
        rdata_d = 32'h00000000;
        unique case (idx)
            EIMA_IDX_EVT_A: begin
                rdata_d[4:0] = evt_q[0][4:0];
                rdata_d[EIMA_BIT_SUM_B] = evt_q[1] != 8'h00;
                rdata_d[EIMA_BIT_SUM_C] = (evt_q[1] | evt_q[2]) != 8'h00;
                rdata_d[EIMA_BIT_SUM_D] = (evt_q[1] | evt_q[2] | evt_q[3]) != 8'h00;
            end
            EIMA_IDX_EVT_B:  rdata_d[7:0] = evt_q[1];
            EIMA_IDX_EVT_C:  rdata_d[7:0] = evt_q[2];
            EIMA_IDX_EVT_D:  rdata_d[7:0] = evt_q[3];
            EIMA_IDX_MASK_A: rdata_d[7:0] = mask_q[0];
            EIMA_IDX_MASK_B: rdata_d[7:0] = mask_q[1];
            EIMA_IDX_MASK_C: rdata_d[7:0] = mask_q[2];
            EIMA_IDX_MASK_D: rdata_d[7:0] = mask_q[3];
            EIMA_IDX_CTRL:   rdata_d[1:0] = {pu_block_q, irq_q};
            default:         rdata_d = 32'h00000000;
        endcase
    end

    // one wait state: access answered on the second access edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            ready_q <= psel & penable & ~ready_q;
            pready  <= psel & penable & ~ready_q;
            pslverr <= psel & penable & ~ready_q & ~mapped;
            // error and write answers carry zero data, never a stale read
            if (psel & penable & ~ready_q) prdata <= (rd_acc && mapped) ? rdata_d : 32'h00000000;
        end
    end
endmodule : eima_top

// file: hdl/eima_pkg.sv
// package for the event interrupt mask aggregator
// Operation
// - writing back the read value clears each set event flag
// - interrupt line stays asserted until every unmasked event bit is cleared
// - charger wake rising edge sets second register bit 0
// - junction high temperature sets second register bit 1
// - third register holds general input 0..7 event flags
// - analog inputs 1..3 threshold crossings also set third register bits 0..2
// - fourth register holds inputs 8..15; bit 6 also set by fast port address
// - first mask register bits 0..4 mask system events; 7..5 reserved
// - second mask register bits 7..0 mask supply events
// - third mask register masks inputs 0..7 and analog thresholds
// - fourth mask register masks inputs 8..15 and fast port address
// - line asserts on unmasked event; held masked during power-up until cleared
// - events arriving during a clear are held and entered afterwards
// - first register summary bits show later registers have events
package eima_pkg;
    localparam logic [7:0] EIMA_IDX_EVT_A  = 8'h06;
    localparam logic [7:0] EIMA_IDX_EVT_B  = 8'h07;
    localparam logic [7:0] EIMA_IDX_EVT_C  = 8'h08;
    localparam logic [7:0] EIMA_IDX_EVT_D  = 8'h09;
    localparam logic [7:0] EIMA_IDX_MASK_A = 8'h0A;
    localparam logic [7:0] EIMA_IDX_MASK_B = 8'h0B;
    localparam logic [7:0] EIMA_IDX_MASK_C = 8'h0C;
    localparam logic [7:0] EIMA_IDX_MASK_D = 8'h0D;
    localparam logic [7:0] EIMA_IDX_CTRL   = 8'h0E;
    localparam int         EIMA_BIT_WAKE   = 0;
    localparam int         EIMA_BIT_TEMP   = 1;
    localparam int         EIMA_BIT_FAST   = 6;
    localparam int         EIMA_BIT_SUM_B  = 5;
    localparam int         EIMA_BIT_SUM_C  = 6;
    localparam int         EIMA_BIT_SUM_D  = 7;
    localparam logic [7:0] EIMA_MASK_A_IMPL = 8'h1F;
    localparam logic [7:0] EIMA_MASK_RESET  = 8'h00;
    localparam logic [7:0] EIMA_EVT_RESET   = 8'h00;

    typedef struct packed {
        logic [4:0] system_evt;
        logic [7:0] supply_evt;
        logic [7:0] input_lo_evt;
        logic [7:0] input_hi_evt;
    } eima_src_t;

    function automatic logic [31:0] eima_addr(input logic [7:0] idx);
        eima_addr = {22'h000000, idx, 2'h0};
    endfunction : eima_addr
endpackage : eima_pkg

// file: tb/eima_chk.sv
// port assertions for the event interrupt aggregator
`timescale 1ns/100ps
module eima_chk (
    input wire logic        core_clk, rst_n, psel, penable, pready, pslverr,
    input wire logic        power_up_active, interrupt_request_line_n, irq_q,
    input wire logic [31:0] prdata
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_ans; psel && penable && !pready |-> ##[1:2] pready; endproperty
    a_ans: assert property (p_ans) else $error("no ready");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("lone error");
    property p_erd; pready && pslverr |-> prdata == 32'h0; endproperty
    a_erd: assert property (p_erd) else $error("error data");
    property p_copy; irq_q == !interrupt_request_line_n; endproperty
    a_copy: assert property (p_copy) else $error("line copy");
    property p_pwr; power_up_active [*3] |-> !irq_q; endproperty
    a_pwr: assert property (p_pwr) else $error("line in power-up");
    property p_rise; $rose(irq_q) |-> !$past(power_up_active); endproperty
    a_rise: assert property (p_rise) else $error("rise in power-up");
    property p_hold; irq_q && !psel && !$past(psel) && !power_up_active |=> irq_q; endproperty
    a_hold: assert property (p_hold) else $error("line dropped");
endmodule : eima_chk
bind eima_top eima_chk u_chk (.*);

// file: tb/eima_host.sv
// host model: apb master servicing the event registers
`timescale 1ns/100ps
module eima_host (
    input  wire logic        core_clk, pready, pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel, penable, pwrite,
    output logic [31:0]      paddr, pwdata,
    output logic [3:0]       pstrb
);
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = {67'h0, 4'h1};
    // idle edge first, so back-to-back calls never drive psel twice at once
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic er);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {22'h0, idx, 2'h0};
        pwdata  <= {24'h0, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge core_clk); while (pready !== 1'b1 && ++n < 50);
        rd = prdata[7:0];
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~pwdata;
    endtask : xfer
endmodule : eima_host

// file: tb/tb_top.sv
// self-checking bench for the event interrupt aggregator
`timescale 1ns/100ps
module tb_top;
    import eima_pkg::*;
    logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
    logic        charger_wake_input, temp_high_evt, fast_two_wire_port_hit;
    logic        power_up_active, interrupt_request_line_n, irq_q;
    logic [31:0] paddr, pwdata, prdata;
    logic [15:0] general_input_evt;
    logic [7:0]  supply_evt, rv;
    logic [4:0]  system_evt;
    logic [3:0]  pstrb;
    logic [2:0]  analog_threshold_evt;
    int          fail_count, checks, cyc;
    eima_top  u_eima_top (.*);
    eima_host u_host (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        u_host.xfer(1'b0, idx, 8'h00, rv, er);
        chk(rv, exp);
    endtask : rd
    task automatic clr(input logic [7:0] idx, input logic [7:0] exp);
        rd(idx, exp);
        u_host.xfer(1'b1, idx, rv, rv, er);
    endtask : clr
    // line lags the event register by one cycle
    task automatic line(input logic exp);
        repeat (3) @(posedge core_clk);
        chk({7'h0, interrupt_request_line_n}, {7'h0, exp});
    endtask : line
    task automatic t_masks();
        for (int i = 10; i < 14; i++) begin
            rd(8'(i), EIMA_MASK_RESET);
            u_host.xfer(1'b1, 8'(i), 8'hFF, rv, er);
            rd(8'(i), (i == 10) ? EIMA_MASK_A_IMPL : 8'hFF);
            u_host.xfer(1'b1, 8'(i), 8'h00, rv, er);
        end
        rd(8'h30, 8'h00);
        chk({7'h0, er}, 8'h01);
    endtask : t_masks
    task automatic t_wake();
        @(posedge core_clk) charger_wake_input <= 1'b1;
        line(1'b0);
        clr(EIMA_IDX_EVT_B, 8'h01);
        line(1'b1);
    endtask : t_wake
    task automatic t_multi();
        @(posedge core_clk) temp_high_evt <= 1'b1;
        fast_two_wire_port_hit <= 1'b1;
        @(posedge core_clk) temp_high_evt <= 1'b0;
        fast_two_wire_port_hit <= 1'b0;
        clr(EIMA_IDX_EVT_A, 8'hE0);
        clr(EIMA_IDX_EVT_B, 8'h02);
        line(1'b0);
        rd(EIMA_IDX_EVT_A, 8'h80);
        clr(EIMA_IDX_EVT_D, 8'h40);
        line(1'b1);
    endtask : t_multi
    task automatic t_inputs();
        u_host.xfer(1'b1, EIMA_IDX_MASK_C, 8'h01, rv, er);
        @(posedge core_clk) analog_threshold_evt <= 3'h1;
        @(posedge core_clk) analog_threshold_evt <= 3'h0;
        line(1'b1);
        clr(EIMA_IDX_EVT_C, 8'h01);
        @(posedge core_clk) general_input_evt <= 16'hFFFF;
        @(posedge core_clk) general_input_evt <= 16'h0000;
        clr(EIMA_IDX_EVT_C, 8'hFF);
        clr(EIMA_IDX_EVT_D, 8'hFF);
        line(1'b1);
    endtask : t_inputs
    task automatic t_power();
        @(posedge core_clk) power_up_active <= 1'b1;
        system_evt <= 5'h10;
        @(posedge core_clk) system_evt <= 5'h00;
        power_up_active <= 1'b0;
        line(1'b1);
        clr(EIMA_IDX_EVT_A, 8'h10);
        @(posedge core_clk) system_evt <= 5'h01;
        @(posedge core_clk) system_evt <= 5'h00;
        line(1'b0);
        clr(EIMA_IDX_EVT_A, 8'h01);
        line(1'b1);
    endtask : t_power
    task automatic end_sim();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        {rst_n, charger_wake_input, temp_high_evt, fast_two_wire_port_hit} = 4'h0;
        {general_input_evt, supply_evt, system_evt, analog_threshold_evt} = 32'h0;
        power_up_active = 1'b1;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        power_up_active <= 1'b0;
        t_masks();
        t_wake();
        t_multi();
        t_inputs();
        t_power();
        end_sim();
    end
endmodule : tb_top
